//--- stc_pkg.sv
// Package for the sixteen-bit timer/counter: register map, control fields,
// reset values and the compare-unit carrier.
// Assumes a 32-bit AHB-Lite bus with one aligned word per register.
package stc_pkg;

    // Register byte addresses
    localparam logic [7:0] STC_ADDR_COUNT_LOW = 8'h00;
    localparam logic [7:0] STC_ADDR_COUNT_HIGH = 8'h04;
    localparam logic [7:0] STC_ADDR_FLAG = 8'h08;
    localparam logic [7:0] STC_ADDR_ENABLE = 8'h0c;
    localparam logic [7:0] STC_ADDR_CONTROL = 8'h10;
    localparam logic [7:0] STC_ADDR_STATUS = 8'h14;

    // Control field positions
    localparam int STC_CTL_RUN = 0;
    localparam int STC_CTL_CLKSRC = 1;
    localparam int STC_CTL_SYNCBYP = 2;
    localparam int STC_CTL_OSCEN = 3;
    localparam int STC_CTL_PS_LO = 4;
    localparam int STC_CTL_PS_HI = 5;
    localparam int STC_CTL_W = 6;

    // Flag, enable and status bit positions
    localparam int STC_FLAG_OVF = 0;
    localparam int STC_EN_OVF = 0;
    localparam int STC_STAT_ARMED = 0;
    localparam int STC_STAT_TBASE = 1;

    // Control reset value and instruction-clock tick phase
    localparam logic [5:0] STC_CTL_RST = 6'h00;
    localparam logic [1:0] STC_PHASE_LAST = 2'h3;

    // Count limits
    localparam logic [15:0] STC_COUNT_MAX = 16'hffff;
    localparam logic [15:0] STC_COUNT_ZERO = 16'h0000;

    // Compare-unit mode that clears the count
    localparam logic [3:0] STC_CMP_SPECIAL = 4'hb;

    typedef struct packed {
        logic [3:0] mode;
        logic trig;
    } stc_cmp_s;

endpackage : stc_pkg

//--- stc_timer.sv
// Sixteen-bit timer/counter with AHB-Lite register slave.
// Assumes hclk is the oscillator clock; pins and crystal input are asynchronous.
//
// Overview of operation
// RL1: Sixteen-bit count wraps from all-ones to zero
// RL2: Wrap sets overflow flag; enable gates interrupt
// RL3: Clock source bit picks external or quarter clock
// RL4: Run bit starts and stops counting
// RL5: Prescale bits give divide by 1,2,4,8
// RL6: Oscillator enable forces pins input, read zero
// RL7: Counter source is crystal pin or count pin
// RL8: Sync bit bypasses synchronizing for external source
// RL9: Rising edges ignored until first falling edge
// RL10: Prescaler ahead of synchronizer, fed by input
// RL11: Synchronized counter holds in sleep, prescaler runs
// RL12: Asynchronous counter runs in sleep, wakes
// RL13: Asynchronous mode gives no compare time base
// RL14: Count bytes read back valid while counting
// RL15: Software stops counter before writing count
// RL16: Special event trigger code clears the count
// RL17: Trigger clear never sets overflow flag
// RL18: Trigger clear works in timer, sync modes
// RL19: Count write wins over same-cycle trigger
// RL20: Control bits 7-6 read as zero
// RL21: Software waits for crystal start-up
// RL22: Count byte write clears the prescaler
// RL23: Power-on reset clears control to zero
// RL24: Reset leaves count; only trigger clears
// RL25: Software clears the overflow flag by writing
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module stc_timer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic external_count_pin,
    input wire logic crystal_in_pin,
    input wire logic [1:0] port_c_direction,
    output logic [1:0] pin_dir_eff,
    output logic pin_read_zero,
    output logic crystal_osc_enable,
    input wire logic sleep_mode,
    input wire stc_pkg::stc_cmp_s cmp1,
    input wire stc_pkg::stc_cmp_s cmp2,
    output logic overflow_irq,
    output logic [15:0] timebase,
    output logic timebase_valid
);
    import stc_pkg::*;

    typedef struct packed {
        logic [5:0] ctrl;
        logic flag;
        logic ien;
        logic armed;
        logic [2:0] pre;
        logic [1:0] phase;
        logic [1:0] pin_s1;
        logic [1:0] pin_s2;
        logic src_d;
        logic ap_valid;
        logic ap_write;
        logic [7:0] ap_addr;
        logic [31:0] rdata;
    } stc_state_s;

    stc_state_s st_r;
    stc_state_s st_nxt;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;

    logic run;
    logic ext_sel;
    logic async_mode;
    logic src_lvl;
    logic rise;
    logic fall;
    logic src_evt;
    logic [2:0] ps_mask;
    logic pre_tick;
    logic adv;
    logic trig;
    logic wr_lo;
    logic wr_hi;
    logic cnt_wr;
    logic ovf_evt;
    logic addr_phase;
    logic [31:0] rd_val;

    // Mode decode
    assign run = st_r.ctrl[STC_CTL_RUN];
    assign ext_sel = st_r.ctrl[STC_CTL_CLKSRC];
    assign async_mode = ext_sel && st_r.ctrl[STC_CTL_SYNCBYP]; // see RL8

    // Source pin choice and edge detect on synchronized levels
    assign src_lvl = st_r.ctrl[STC_CTL_OSCEN] ? st_r.pin_s2[1] : st_r.pin_s2[0]; // see RL7
    assign rise = src_lvl && !st_r.src_d;
    assign fall = !src_lvl && st_r.src_d;

    // Source event: external rising edge after arming, or instruction clock
    always_comb begin
        if (ext_sel) begin
            src_evt = run && st_r.armed && rise; // see RL3 // see RL9
        end else begin
            src_evt = run && !sleep_mode && (st_r.phase == STC_PHASE_LAST); // see RL3 // see RL4
        end
    end

    // Prescale divide ratio
    always_comb begin
        case (st_r.ctrl[STC_CTL_PS_HI:STC_CTL_PS_LO]) // see RL5
            2'h0: ps_mask = 3'h0;
            2'h1: ps_mask = 3'h1;
            2'h2: ps_mask = 3'h3;
            default: ps_mask = 3'h7;
        endcase
    end

    // Prescaler runs ahead of the synchronized count stage
    assign pre_tick = src_evt && ((st_r.pre & ps_mask) == ps_mask); // see RL10
    // Synchronized counter stalls in sleep; asynchronous keeps going
    assign adv = pre_tick && !(sleep_mode && ext_sel && !async_mode); // see RL11 // see RL12

    // Special event trigger from either compare unit
    assign trig = (cmp1.trig && cmp1.mode == STC_CMP_SPECIAL)
        || (cmp2.trig && cmp2.mode == STC_CMP_SPECIAL); // see RL16 // see RL18

    // Bus data phase decode
    assign wr_lo = st_r.ap_valid && st_r.ap_write && st_r.ap_addr == STC_ADDR_COUNT_LOW;
    assign wr_hi = st_r.ap_valid && st_r.ap_write && st_r.ap_addr == STC_ADDR_COUNT_HIGH;
    assign cnt_wr = wr_lo || wr_hi;
    assign ovf_evt = adv && !cnt_wr && !trig && (cnt_r == STC_COUNT_MAX); // see RL1 // see RL17
    assign addr_phase = hsel && htrans[1] && hready;

    // Count update
    always_comb begin
        cnt_nxt = cnt_r;
        if (cnt_wr) begin
            if (wr_lo) begin
                cnt_nxt[7:0] = hwdata[7:0]; // see RL19
            end
            if (wr_hi) begin
                cnt_nxt[15:8] = hwdata[7:0]; // see RL19
            end
        end else if (trig) begin
            cnt_nxt = STC_COUNT_ZERO; // see RL16
        end else if (adv) begin
            cnt_nxt = cnt_r + 16'h0001; // see RL1
        end
    end

    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.pin_s1 = {crystal_in_pin, external_count_pin};
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.src_d = src_lvl;
        st_nxt.phase = st_r.phase + 2'h1;
        // Arming needs one falling edge after enabling counter mode
        if (!(run && ext_sel)) begin
            st_nxt.armed = 1'b0; // see RL9
        end else if (fall) begin
            st_nxt.armed = 1'b1; // see RL9
        end
        if (cnt_wr) begin
            st_nxt.pre = 3'h0; // see RL22
        end else if (src_evt) begin
            st_nxt.pre = st_r.pre + 3'h1; // see RL10
        end
        // Register writes in the data phase
        if (st_r.ap_valid && st_r.ap_write) begin
            if (st_r.ap_addr == STC_ADDR_CONTROL) begin
                st_nxt.ctrl = hwdata[STC_CTL_W-1:0];
            end else if (st_r.ap_addr == STC_ADDR_ENABLE) begin
                st_nxt.ien = hwdata[STC_EN_OVF];
            end else if (st_r.ap_addr == STC_ADDR_FLAG && !hwdata[STC_FLAG_OVF]) begin
                st_nxt.flag = 1'b0; // see RL25
            end
        end
        // Overflow set wins over a software clear
        if (ovf_evt) begin
            st_nxt.flag = 1'b1; // see RL2
        end
        st_nxt.ap_valid = addr_phase;
        st_nxt.ap_write = hwrite;
        st_nxt.ap_addr = haddr;
        // Read data reflects any write committing at the same edge
        rd_val = 32'h0000_0000;
        if (haddr == STC_ADDR_COUNT_LOW) begin
            rd_val[7:0] = cnt_nxt[7:0]; // see RL14
        end else if (haddr == STC_ADDR_COUNT_HIGH) begin
            rd_val[7:0] = cnt_nxt[15:8]; // see RL14
        end else if (haddr == STC_ADDR_FLAG) begin
            rd_val[STC_FLAG_OVF] = st_nxt.flag;
        end else if (haddr == STC_ADDR_ENABLE) begin
            rd_val[STC_EN_OVF] = st_nxt.ien;
        end else if (haddr == STC_ADDR_CONTROL) begin
            rd_val[STC_CTL_W-1:0] = st_nxt.ctrl; // see RL20
        end else if (haddr == STC_ADDR_STATUS) begin
            rd_val[STC_STAT_ARMED] = st_nxt.armed;
            rd_val[STC_STAT_TBASE] = !(st_nxt.ctrl[STC_CTL_CLKSRC]
                && st_nxt.ctrl[STC_CTL_SYNCBYP]);
        end
        if (addr_phase && !hwrite) begin
            st_nxt.rdata = rd_val;
        end
    end

    // Block state, cleared on power-on reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
            st_r.ctrl <= STC_CTL_RST; // see RL23
        end else begin
            st_r <= st_nxt;
        end
    end

    // Count holds through every reset
    always_ff @(posedge hclk) begin
        cnt_r <= cnt_nxt; // see RL24
    end

    // Outputs
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_r.rdata;
    assign overflow_irq = st_r.flag && st_r.ien; // see RL2 // see RL12
    assign crystal_osc_enable = st_r.ctrl[STC_CTL_OSCEN]; // see RL6
    assign pin_dir_eff = st_r.ctrl[STC_CTL_OSCEN] ? 2'h3 : port_c_direction; // see RL6
    assign pin_read_zero = st_r.ctrl[STC_CTL_OSCEN]; // see RL6
    assign timebase = cnt_r;
    assign timebase_valid = !async_mode; // see RL13

    // Checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic [7:0] wr_byte_h;
    assign wr_byte_h = hwdata[7:0];

    // Count holds no reset value; checks on it wait until it is loaded
    logic cnt_known_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_known_r <= 1'b0;
        end else if (cnt_wr || trig) begin
            cnt_known_r <= 1'b1;
        end
    end

    logic flag_clr;
    assign flag_clr = st_r.ap_valid && st_r.ap_write && st_r.ap_addr == STC_ADDR_FLAG
        && !hwdata[STC_FLAG_OVF];

    sequence seq_quiet3;
        !src_evt [*3];
    endsequence

    sequence seq_wrap;
        adv && !cnt_wr && !trig && cnt_r == STC_COUNT_MAX;
    endsequence

    sequence seq_trig_only;
        trig && !cnt_wr;
    endsequence

    AST_WRAP_FLAG: assert property (seq_wrap |=> cnt_r == STC_COUNT_ZERO && st_r.flag) // see RL1
        else $error("Wrap did not reach zero with flag set");
    AST_IRQ_OUT: assert property (ovf_evt && st_r.ien |=> overflow_irq) // see RL2
        else $error("Overflow with enable gave no interrupt");
    AST_TIMER_RATE: assert property (!ext_sel && src_evt |=> seq_quiet3) // see RL3
        else $error("Internal clock faster than one in four");
    AST_STOPPED: assert property (cnt_known_r && !run && !cnt_wr && !trig // see RL4
        |=> cnt_r == $past(cnt_r))
        else $error("Stopped counter changed");
    AST_UNARMED: assert property (ext_sel && !st_r.armed |-> !src_evt) // see RL9
        else $error("Edge counted before falling edge");
    AST_SYNC_SLEEP: assert property (cnt_known_r && sleep_mode && ext_sel && !async_mode // see RL11
        && !cnt_wr && !trig |=> cnt_r == $past(cnt_r))
        else $error("Synchronized counter moved in sleep");
    AST_TRIG_CLR: assert property (seq_trig_only |=> cnt_r == STC_COUNT_ZERO) // see RL16
        else $error("Trigger did not clear count");
    AST_TRIG_NOFLAG: assert property (trig && !cnt_wr && !st_r.flag |=> !st_r.flag) // see RL17
        else $error("Trigger clear set overflow flag");
    AST_WRITE_WINS: assert property (wr_lo && trig |=> cnt_r[7:0] == $past(wr_byte_h)) // see RL19
        else $error("Trigger beat a count write");
    AST_PRE_CLR: assert property (cnt_wr |=> st_r.pre == 3'h0) // see RL22
        else $error("Count write left prescaler");
    AST_CTRL_READ: assert property (addr_phase && !hwrite && haddr == STC_ADDR_CONTROL // see RL20
        |=> hrdata[31:STC_CTL_W] == '0)
        else $error("Unused control bits read nonzero");

    // Counting, flag, prescaler and pin checks
    AST_INC_ONE: assert property (cnt_known_r && adv && !cnt_wr && !trig // see RL1
        |=> cnt_r == $past(cnt_r) + 16'h0001)
        else $error("Count did not advance by one");
    AST_HOLD_IDLE: assert property (cnt_known_r && !adv && !cnt_wr && !trig // see RL4
        |=> cnt_r == $past(cnt_r))
        else $error("Count moved without an event");
    AST_SET_WINS: assert property (ovf_evt |=> st_r.flag) // see RL2
        else $error("Overflow did not set flag");
    AST_NO_SPUR_FLAG: assert property (!st_r.flag && !ovf_evt |=> !st_r.flag) // see RL2
        else $error("Flag set without overflow");
    AST_FLAG_HOLD: assert property (st_r.flag && !flag_clr |=> st_r.flag) // see RL25
        else $error("Flag dropped without software clear");
    AST_FLAG_CLEAR: assert property (flag_clr && !ovf_evt |=> !st_r.flag) // see RL25
        else $error("Software clear left flag set");
    AST_PS_DIV1: assert property (st_r.ctrl[STC_CTL_PS_HI:STC_CTL_PS_LO] == 2'h0 // see RL5
        && src_evt |-> pre_tick)
        else $error("Divide by one skipped an event");
    AST_PS_DIV2: assert property (st_r.ctrl[STC_CTL_PS_HI:STC_CTL_PS_LO] == 2'h1 // see RL5
        && src_evt && !st_r.pre[0] |-> !pre_tick)
        else $error("Divide by two ticked early");
    AST_PS_DIV8: assert property (st_r.ctrl[STC_CTL_PS_HI:STC_CTL_PS_LO] == 2'h3 // see RL5
        && src_evt && st_r.pre != 3'h7 |-> !pre_tick)
        else $error("Divide by eight ticked early");
    AST_OSC_PINS: assert property (crystal_osc_enable // see RL6
        |-> pin_dir_eff == 2'h3 && pin_read_zero)
        else $error("Oscillator on but pins not forced");
    AST_OSC_OFF: assert property (!crystal_osc_enable // see RL6
        |-> pin_dir_eff == port_c_direction && !pin_read_zero)
        else $error("Oscillator off but pins forced");
    AST_TB_ASYNC: assert property (st_r.ctrl[STC_CTL_CLKSRC] && st_r.ctrl[STC_CTL_SYNCBYP] // see RL13
        |-> !timebase_valid)
        else $error("Asynchronous count offered as time base");
    AST_TB_SYNC: assert property (!st_r.ctrl[STC_CTL_CLKSRC] // see RL8
        |-> timebase_valid)
        else $error("Sync bit not ignored in timer mode");
    AST_ASYNC_SLEEP: assert property (async_mode && pre_tick |-> adv) // see RL12
        else $error("Asynchronous counter stalled");
    AST_TIMER_SLEEP: assert property (!ext_sel && sleep_mode |-> !src_evt) // see RL3
        else $error("Instruction clock ran in sleep");
    AST_ARM_DROP: assert property (!(run && ext_sel) |=> !st_r.armed) // see RL9
        else $error("Arming kept outside counter mode");
    AST_ARM_SET: assert property (run && ext_sel && fall |=> st_r.armed) // see RL9
        else $error("Falling edge did not arm");
    AST_PRE_HOLD: assert property (!src_evt && !cnt_wr // see RL10
        |=> st_r.pre == $past(st_r.pre))
        else $error("Prescaler moved without event");
    AST_PRE_STEP: assert property (src_evt && !cnt_wr // see RL10
        |=> st_r.pre == $past(st_r.pre) + 3'h1)
        else $error("Prescaler missed an event");
    AST_WRITE_HI: assert property (wr_hi && trig // see RL19
        |=> cnt_r[15:8] == $past(wr_byte_h))
        else $error("Trigger beat a high byte write");
    AST_CNT_READ: assert property (addr_phase && !hwrite && haddr == STC_ADDR_COUNT_HIGH // see RL14
        |=> hrdata[31:8] == '0)
        else $error("Count byte read carried extra bits");
    AST_CTRL_RESET: assert property ($rose(hresetn) |-> st_r.ctrl == STC_CTL_RST) // see RL23
        else $error("Control not cleared by reset");
    AST_STAT_READ: assert property (addr_phase && !hwrite && haddr == STC_ADDR_STATUS // see RL9
        |=> hrdata[STC_STAT_ARMED] == st_r.armed)
        else $error("Status armed bit wrong");
    AST_IRQ_MASK: assert property (!st_r.ien |-> !overflow_irq) // see RL2
        else $error("Masked overflow raised interrupt");
    AST_RUN_GATE: assert property (!run |-> !src_evt) // see RL4
        else $error("Stopped counter took an event");
    AST_SYNC_NOADV: assert property (sleep_mode && ext_sel && !async_mode |-> !adv) // see RL11
        else $error("Synchronized stage ran in sleep");
    AST_TIMER_PHASE: assert property (!ext_sel && src_evt |-> st_r.phase == STC_PHASE_LAST) // see RL3
        else $error("Instruction tick off phase");
    AST_CLR_NO_OVF: assert property (seq_trig_only |-> !ovf_evt) // see RL17
        else $error("Trigger clear raised overflow");

endmodule // stc_timer

`default_nettype wire

//--- stc_pin_model.sv
// Far-side model: drives the count pin and the crystal pin.
// Assumes each level is held long enough for the two-flop input sync.
`timescale 1ns/1ps
`default_nettype none
module stc_pin_model (
    input wire logic hclk,
    output logic external_count_pin,
    output logic crystal_in_pin
);
    initial begin
        external_count_pin = 1'b0;
        crystal_in_pin = 1'b0;
    end
    // Four cycles per level, above the three-cycle minimum
    task automatic pulses(input int n, input bit xtal);
        for (int i = 0; i < n; i++) begin
            repeat (4) @(posedge hclk);
            {crystal_in_pin, external_count_pin} <= xtal ? 2'b10 : 2'b01;
            repeat (4) @(posedge hclk);
            {crystal_in_pin, external_count_pin} <= 2'b00;
        end
        repeat (6) @(posedge hclk);
    endtask
endmodule // stc_pin_model
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the timer/counter over AHB-Lite.
// Assumes zero-wait slave and the pin model on the count inputs.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin failures++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module testbench;
    import stc_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, sleep_mode;
    logic [7:0] haddr;
    logic [1:0] htrans, port_c_direction, pin_dir_eff;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, r, q;
    logic ext_pin, xtal_pin, pin_read_zero, crystal_osc_enable, overflow_irq, timebase_valid;
    logic [15:0] timebase, c, d;
    stc_cmp_s cmp1, cmp2;
    int failures, checks;
    logic [7:0] cfg [7] = '{8'h03, 8'h13, 8'h23, 8'h33, 8'h0b, 8'h03, 8'h07};
    logic [15:0] expc [7] = '{16'h10, 16'h8, 16'h4, 16'h2, 16'h10, 16'h0, 16'h10};
    stc_timer stc_timer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .external_count_pin(ext_pin),
        .crystal_in_pin(xtal_pin), .port_c_direction(port_c_direction),
        .pin_dir_eff(pin_dir_eff), .pin_read_zero(pin_read_zero),
        .crystal_osc_enable(crystal_osc_enable), .sleep_mode(sleep_mode), .cmp1(cmp1),
        .cmp2(cmp2), .overflow_irq(overflow_irq), .timebase(timebase),
        .timebase_valid(timebase_valid));
    stc_pin_model stc_pin_model_i (.hclk(hclk), .external_count_pin(ext_pin),
        .crystal_in_pin(xtal_pin));
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (hreadyout !== 1'b1) begin
            failures++;
            report_and_stop();
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        hsel <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d, q);
        #1;
    endtask
    task automatic rdcnt(output logic [15:0] v);
        xfer(STC_ADDR_COUNT_LOW, 1'b0, 32'h0, r);
        xfer(STC_ADDR_COUNT_HIGH, 1'b0, 32'h0, q);
        v = {q[7:0], r[7:0]};
    endtask
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    initial begin
        {hresetn, hsel, hwrite, sleep_mode, haddr, htrans, hwdata} = '0;
        hsize = 3'h2;
        port_c_direction = 2'b01;
        cmp1 = '0;
        cmp2 = '0;
        failures = 0;
        checks = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(STC_ADDR_CONTROL, 1'b0, 32'h0, r);
        `CHK("control reset", 32'h0, r)
        `CHK("okay", 1'b0, hresp)
        wr(STC_ADDR_CONTROL, 32'hfe);
        xfer(STC_ADDR_CONTROL, 1'b0, 32'h0, r);
        `CHK("control bits", 32'h3e, r)
        `CHK("pin dir osc", 2'b11, pin_dir_eff)
        `CHK("pin zero", 1'b1, pin_read_zero)
        `CHK("osc on", 1'b1, crystal_osc_enable)
        wr(STC_ADDR_CONTROL, 32'h0);
        `CHK("pin dir", 2'b01, pin_dir_eff)
        wr(8'h20, 32'hff);
        xfer(8'h20, 1'b0, 32'h0, r);
        `CHK("unmapped", 32'h0, r)
        $display("test registers done");
        wr(STC_ADDR_COUNT_LOW, 32'hff);
        wr(STC_ADDR_COUNT_HIGH, 32'hff);
        wr(STC_ADDR_CONTROL, 32'h01);
        repeat (12) @(posedge hclk);
        wr(STC_ADDR_CONTROL, 32'h0);
        rdcnt(c);
        `CHK("wrap high", 8'h00, c[15:8])
        repeat (20) @(posedge hclk);
        rdcnt(d);
        `CHK("stopped", c, d)
        xfer(STC_ADDR_FLAG, 1'b0, 32'h0, r);
        `CHK("flag set", 32'h1, r)
        `CHK("irq masked", 1'b0, overflow_irq)
        wr(STC_ADDR_ENABLE, 32'h1);
        `CHK("irq on", 1'b1, overflow_irq)
        wr(STC_ADDR_FLAG, 32'h0);
        `CHK("irq off", 1'b0, overflow_irq)
        $display("test wrap done");
        wr(STC_ADDR_COUNT_LOW, 32'h34);
        wr(STC_ADDR_COUNT_HIGH, 32'h12);
        cmp2 <= '{4'ha, 1'b1};
        @(posedge hclk);
        cmp2 <= '{4'ha, 1'b0};
        rdcnt(c);
        `CHK("other mode", 16'h1234, c)
        cmp1 <= '{STC_CMP_SPECIAL, 1'b1};
        @(posedge hclk);
        cmp1 <= '{STC_CMP_SPECIAL, 1'b0};
        rdcnt(c);
        `CHK("trigger clear", 16'h0, c)
        xfer(STC_ADDR_FLAG, 1'b0, 32'h0, r);
        `CHK("no flag", 32'h0, r)
        cmp1 <= '{STC_CMP_SPECIAL, 1'b1};
        wr(STC_ADDR_COUNT_LOW, 32'h5a);
        cmp1 <= '{STC_CMP_SPECIAL, 1'b0};
        rdcnt(c);
        `CHK("write wins", 16'h005a, c)
        $display("test trigger done");
        for (int i = 0; i < 7; i++) begin
            // Stop before writing the count
            wr(STC_ADDR_CONTROL, 32'h0);
            wr(STC_ADDR_COUNT_LOW, 32'h0);
            wr(STC_ADDR_COUNT_HIGH, 32'h0);
            sleep_mode <= (i > 4);
            wr(STC_ADDR_CONTROL, {24'h0, cfg[i]});
            // Crystal start-up delay before relying on it
            repeat (20) @(posedge hclk);
            stc_pin_model_i.pulses(17, cfg[i][3]);
            `CHK("valid", cfg[i] != 8'h07, timebase_valid)
            sleep_mode <= 1'b0;
            rdcnt(c);
            `CHK("count", expc[i], c)
            `CHK("timebase", expc[i], timebase)
        end
        $display("test counter done");
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
